// file: logic/dhb_pkg.sv
package dhb_pkg;
    localparam int DATA_W = 8;

    // build-time interface option, one of four
    typedef enum logic [1:0] {
        DHB_SPI3  = 2'h0,
        DHB_SPI4  = 2'h1,
        DHB_M6800 = 2'h2,
        DHB_I8080 = 2'h3
    } dhb_mode_t;

    // serial pins sit on the data bus
    localparam int SCLK_BIT = 0;
    localparam int SERIAL_DATA_IN_BIT = 1;

    // host pin timing in ns
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_PAR_STROBE_NS = 150;
    localparam int T_SER_HALF_NS = 200;

    // least times round up to whole cycles, never below one
    function automatic int dhb_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PAR_STROBE_CYC = dhb_cycles(T_PAR_STROBE_NS);
    localparam int SER_HALF_CYC = dhb_cycles(T_SER_HALF_NS);
    localparam int CNT_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
endpackage : dhb_pkg

// file: logic/dhb_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dhb_if;
    import dhb_pkg::*;
    // host drives data bus on writes
    logic [DATA_W-1:0] hd_o;
    logic              hd_oe;
    // module drives data bus on reads
    logic [DATA_W-1:0] dd_o;
    logic              dd_oe;
    logic [DATA_W-1:0] host_data_bus;
    logic              rd_strobe;
    logic              wr_strobe;
    logic              cs_n;
    logic              data_command_select;
    logic              init_n;

    // resolved bus level; pull-down when undriven
    assign host_data_bus = hd_oe ? hd_o : (dd_oe ? dd_o : '0);

    modport dev (
        input  host_data_bus, rd_strobe, wr_strobe, cs_n, data_command_select, init_n,
        output dd_o, dd_oe
    );
    modport host (
        input  host_data_bus,
        output hd_o, hd_oe, rd_strobe, wr_strobe, cs_n, data_command_select, init_n
    );
endinterface : dhb_if
`default_nettype wire

// file: logic/dhb_host.sv
`timescale 1ns/10ps
`default_nettype none
module dhb_host
    import dhb_pkg::*;
#(
    parameter dhb_mode_t MODE = DHB_I8080
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // request
    input  wire logic              req_valid,
    input  wire logic              req_read,
    input  wire logic              req_dc,
    input  wire logic [DATA_W-1:0] req_data,
    input  wire logic              req_init,
    output logic                   req_ready,
    // answer
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    // link
    dhb_if.host                    bus
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_ACT = 4'b0100,
        ST_DONE = 4'b1000
    } dhb_hst_t;

    localparam bit SER = (MODE == DHB_SPI3) || (MODE == DHB_SPI4);
    localparam logic [CNT_W-1:0] WAIT_PAR = CNT_W'(PAR_STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] WAIT_SER = CNT_W'(SER_HALF_CYC - 1);

    dhb_hst_t          st_r, st_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [2:0]        bit_r, bit_nxt;
    logic              rd_r, rd_nxt, wr_r, wr_nxt, cs_r, cs_nxt, dc_r, dc_nxt, ini_r, ini_nxt;
    logic              oe_r, oe_nxt, isrd_r, isrd_nxt, rv_r, rv_nxt;
    logic [DATA_W-1:0] d_r, d_nxt, rdat_r, rdat_nxt;
    // serial byte kept apart: bits 0 and 1 of d_r carry the clock and data pins
    logic [DATA_W-1:0] sb_r, sb_nxt;

    // idle strobe levels per option
    localparam logic RD_IDLE = (MODE == DHB_I8080);
    localparam logic WR_IDLE = (MODE == DHB_I8080);

    always_comb begin
        st_nxt = st_r; cnt_nxt = cnt_r; bit_nxt = bit_r;
        rd_nxt = rd_r; wr_nxt = wr_r; cs_nxt = cs_r; dc_nxt = dc_r;
        ini_nxt = ini_r; oe_nxt = oe_r; isrd_nxt = isrd_r;
        d_nxt = d_r; rdat_nxt = rdat_r; rv_nxt = 1'b0;
        sb_nxt = sb_r;
        if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end else begin
            unique case (st_r)
                ST_IDLE: if (req_valid) begin
                    ini_nxt = ~req_init;
                    cs_nxt = req_init;  // init pulse keeps chip deselected
                    dc_nxt = (MODE == DHB_SPI3) ? 1'b0 : req_dc;
                    isrd_nxt = req_read && !SER && !req_init;
                    d_nxt = req_data;
                    sb_nxt = req_data;
                    bit_nxt = '0;
                    if (!SER) begin
                        wr_nxt = (MODE == DHB_M6800) ? isrd_nxt : 1'b1;
                        oe_nxt = !isrd_nxt && !req_init;
                    end else begin
                        oe_nxt = !req_init;
                        d_nxt[SCLK_BIT] = 1'b0;
                    end
                    cnt_nxt = SER ? WAIT_SER : WAIT_PAR;
                    st_nxt = ST_SETUP;
                end
                ST_SETUP: begin
                    if (!ini_r) begin
                        st_nxt = ST_DONE;
                    end else if (SER) begin
                        // msb first on rising serial clock
                        d_nxt[SERIAL_DATA_IN_BIT] = sb_r[DATA_W-1-bit_r];
                        d_nxt[SCLK_BIT] = 1'b0;
                        st_nxt = ST_ACT;
                    end else if (MODE == DHB_M6800) begin
                        rd_nxt = 1'b1;
                        st_nxt = ST_ACT;
                    end else begin
                        if (isrd_r) rd_nxt = 1'b0;
                        else wr_nxt = 1'b0;
                        st_nxt = ST_ACT;
                    end
                    cnt_nxt = SER ? WAIT_SER : WAIT_PAR;
                end
                ST_ACT: begin
                    cnt_nxt = SER ? WAIT_SER : WAIT_PAR;
                    if (SER) begin
                        if (!d_r[SCLK_BIT]) begin
                            d_nxt[SCLK_BIT] = 1'b1;
                        end else begin
                            d_nxt[SCLK_BIT] = 1'b0;
                            bit_nxt = bit_r + 1'b1;
                            st_nxt = (bit_r == BIT_LAST) ? ST_DONE : ST_SETUP;
                        end
                    end else begin
                        if (isrd_r) rdat_nxt = bus.host_data_bus;
                        rd_nxt = RD_IDLE;
                        // direction select must outlive the enable fall, else a read ends as a write
                        if (MODE == DHB_I8080) wr_nxt = WR_IDLE;
                        st_nxt = ST_DONE;
                    end
                end
                default: begin
                    cs_nxt = 1'b1; ini_nxt = 1'b1; oe_nxt = 1'b0;
                    rd_nxt = RD_IDLE; wr_nxt = WR_IDLE;
                    rv_nxt = isrd_r;
                    st_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_r <= ST_IDLE; cnt_r <= '0; bit_r <= '0;
            rd_r <= RD_IDLE; wr_r <= WR_IDLE; cs_r <= 1'b1; dc_r <= 1'b0; ini_r <= 1'b1;
            oe_r <= 1'b0; isrd_r <= 1'b0; d_r <= '0; rdat_r <= '0; rv_r <= 1'b0;
            sb_r <= '0;
        end else begin
            st_r <= st_nxt; cnt_r <= cnt_nxt; bit_r <= bit_nxt;
            rd_r <= rd_nxt; wr_r <= wr_nxt; cs_r <= cs_nxt; dc_r <= dc_nxt; ini_r <= ini_nxt;
            oe_r <= oe_nxt; isrd_r <= isrd_nxt; d_r <= d_nxt; rdat_r <= rdat_nxt; rv_r <= rv_nxt;
            sb_r <= sb_nxt;
        end
    end

    assign req_ready = (st_r == ST_IDLE) && (cnt_r == '0);
    assign rsp_valid = rv_r;
    assign rsp_data = rdat_r;
    assign bus.hd_o = d_r;
    assign bus.hd_oe = oe_r;
    assign bus.rd_strobe = rd_r;
    assign bus.wr_strobe = wr_r;
    assign bus.cs_n = cs_r;
    assign bus.data_command_select = dc_r;
    assign bus.init_n = ini_r;
endmodule : dhb_host
`default_nettype wire

// file: logic/dhb_dev.sv
`timescale 1ns/10ps
`default_nettype none
module dhb_dev
    import dhb_pkg::*;
#(
    parameter dhb_mode_t MODE = DHB_I8080
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // link
    dhb_if.dev                     bus,
    // received bytes and init reset
    output logic                   cmd_valid,
    output logic [DATA_W-1:0]      cmd_byte,
    output logic                   pix_valid,
    output logic [DATA_W-1:0]      pix_byte,
    output logic                   ctrl_reset,
    // read-back sources
    input  wire logic [DATA_W-1:0] status_byte,
    input  wire logic [DATA_W-1:0] read_byte,
    output logic                   read_taken
);
    localparam bit SER = (MODE == DHB_SPI3) || (MODE == DHB_SPI4);
    localparam int SW = DATA_W + 5;

    // two-stage synchronisers on every pin
    logic [SW-1:0] s1_r, s2_r, s3_r;
    logic [SW-1:0] pins;
    assign pins = {bus.host_data_bus, bus.rd_strobe, bus.wr_strobe, bus.cs_n,
                   bus.data_command_select, bus.init_n};

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s1_r <= '1; s2_r <= '1; s3_r <= '1;
        end else begin
            s1_r <= pins; s2_r <= s1_r; s3_r <= s2_r;
        end
    end

    logic [DATA_W-1:0] db, db_d;
    logic rd, wr, cs_n, dc, ini, rd_d, wr_d;
    assign {db, rd, wr, cs_n, dc, ini} = s2_r;
    assign {db_d, rd_d, wr_d} = s3_r[SW-1:3];
    logic sclk_rise;
    assign sclk_rise = db[SCLK_BIT] && !db_d[SCLK_BIT];

    logic [DATA_W-1:0] sh_r, sh_nxt, cb_r, cb_nxt, pb_r, pb_nxt, do_r, do_nxt;
    logic [2:0]        bc_r, bc_nxt;
    logic              cv_r, cv_nxt, pv_r, pv_nxt, oe_r, oe_nxt, rt_r, rt_nxt, cr_r, cr_nxt;

    function automatic void put(input logic is_data, input logic [DATA_W-1:0] b,
                                output logic [DATA_W-1:0] cb, output logic cv,
                                output logic [DATA_W-1:0] pb, output logic pv);
        cb = is_data ? '0 : b;
        cv = !is_data;
        pb = is_data ? b : '0;
        pv = is_data;
    endfunction

    always_comb begin
        logic [DATA_W-1:0] nb;
        nb = '0;
        sh_nxt = sh_r; bc_nxt = bc_r; cb_nxt = cb_r; pb_nxt = pb_r;
        cv_nxt = 1'b0; pv_nxt = 1'b0; rt_nxt = 1'b0;
        do_nxt = do_r; oe_nxt = 1'b0;
        cr_nxt = !ini;
        if (!ini) begin
            bc_nxt = '0;
        end else if (cs_n) begin
            bc_nxt = '0;
        end else if (SER) begin
            if (sclk_rise) begin
                nb = {sh_r[DATA_W-2:0], db[SERIAL_DATA_IN_BIT]};
                sh_nxt = nb;
                bc_nxt = bc_r + 1'b1;
                // three-wire option has select tied low: all commands
                if (bc_r == BIT_LAST) put((MODE == DHB_SPI4) && dc, nb, cb_nxt, cv_nxt, pb_nxt, pv_nxt);
            end
        end else if (MODE == DHB_M6800) begin
            if (rd && wr) begin
                oe_nxt = 1'b1;
                do_nxt = dc ? read_byte : status_byte;
            end
            if (!rd && rd_d) begin
                if (!wr) put(dc, db, cb_nxt, cv_nxt, pb_nxt, pv_nxt);
                else rt_nxt = dc;
            end
        end else begin
            if (!rd) begin
                oe_nxt = 1'b1;
                do_nxt = dc ? read_byte : status_byte;
            end
            if (rd && !rd_d) rt_nxt = dc;
            if (wr && !wr_d) put(dc, db, cb_nxt, cv_nxt, pb_nxt, pv_nxt);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sh_r <= '0; bc_r <= '0; cb_r <= '0; pb_r <= '0; do_r <= '0;
            cv_r <= 1'b0; pv_r <= 1'b0; oe_r <= 1'b0; rt_r <= 1'b0; cr_r <= 1'b1;
        end else begin
            sh_r <= sh_nxt; bc_r <= bc_nxt; cb_r <= cb_nxt; pb_r <= pb_nxt; do_r <= do_nxt;
            cv_r <= cv_nxt; pv_r <= pv_nxt; oe_r <= oe_nxt; rt_r <= rt_nxt; cr_r <= cr_nxt;
        end
    end

    assign bus.dd_o = do_r;
    assign bus.dd_oe = oe_r;
    assign cmd_valid = cv_r;
    assign cmd_byte = cb_r;
    assign pix_valid = pv_r;
    assign pix_byte = pb_r;
    assign read_taken = rt_r;
    assign ctrl_reset = cr_r;
endmodule : dhb_dev
`default_nettype wire

// file: testbench/dhb_props.sv
`timescale 1ns/10ps
`default_nettype none
module dhb_props
    import dhb_pkg::*;
(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              nrst,
    // link
    input wire logic              hd_oe,
    input wire logic              dd_oe,
    input wire logic [DATA_W-1:0] host_data_bus,
    input wire logic              rd_strobe,
    input wire logic              wr_strobe,
    input wire logic              cs_n,
    input wire logic              init_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_no_drive_clash: assert property (!(hd_oe && dd_oe)) else $error("both ends drive the bus");
    a_idle_no_drive: assert property (cs_n [*6] |-> !dd_oe) else $error("device drives while deselected");
    a_read_drives: assert property ($fell(rd_strobe) && !cs_n |-> ##[1:6] dd_oe) else $error("read not driven");
    a_read_release: assert property ($rose(rd_strobe) |-> ##[1:6] !dd_oe) else $error("bus not released");
    a_write_no_drive: assert property (!wr_strobe |-> !dd_oe) else $error("device drives during write");
    a_write_data_held: assert property (!wr_strobe && !cs_n |-> hd_oe && $stable(host_data_bus))
        else $error("write data moved");
    a_read_data_held: assert property (dd_oe && $past(dd_oe) |-> $stable(host_data_bus))
        else $error("read data moved");
    a_strobe_framed: assert property ($fell(wr_strobe) || $fell(rd_strobe) |-> !cs_n)
        else $error("strobe outside chip select");
    a_init_no_access: assert property (!init_n |-> cs_n) else $error("access during init");
endmodule // dhb_props
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dhb_pkg::*;
    logic              sys_clk;
    logic              nrst;
    // pair 0: enable-free 8080 style, pair 1: enable-strobe, pair 2: four-wire serial
    logic [2:0]        req_valid;
    logic              req_read;
    logic              req_dc;
    logic [DATA_W-1:0] req_data;
    logic              req_init;
    logic [2:0]        req_ready;
    logic [2:0]        rsp_valid;
    logic [DATA_W-1:0] rsp_data [3];
    logic [2:0]        cmd_valid;
    logic [DATA_W-1:0] cmd_byte [3];
    logic [2:0]        pix_valid;
    logic [DATA_W-1:0] pix_byte [3];
    logic [2:0]        ctrl_reset;
    logic [2:0]        read_taken;
    // read-back sources held steady so a late sample still matches
    localparam logic [7:0] STAT = 8'hA5;
    localparam logic [7:0] RDAT = 8'h5A;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                n_cmd = 0;
    int                n_pix = 0;
    int                n_rsp = 0;
    int                n_tk = 0;
    logic [7:0]        last_cmd;
    logic [7:0]        last_pix;
    logic [7:0]        last_rsp;

    dhb_if dhb_if_i [3] ();
    for (genvar p = 0; p < 3; p++) begin : g_pair
        localparam dhb_mode_t PM = (p == 0) ? DHB_I8080 : ((p == 1) ? DHB_M6800 : DHB_SPI4);
        dhb_host #(.MODE(PM)) dhb_host_i (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid[p]),
            .req_read(req_read), .req_dc(req_dc), .req_data(req_data), .req_init(req_init),
            .req_ready(req_ready[p]), .rsp_valid(rsp_valid[p]), .rsp_data(rsp_data[p]), .bus(dhb_if_i[p]));
        dhb_dev #(.MODE(PM)) dhb_dev_i (.sys_clk(sys_clk), .nrst(nrst), .bus(dhb_if_i[p]),
            .cmd_valid(cmd_valid[p]), .cmd_byte(cmd_byte[p]), .pix_valid(pix_valid[p]), .pix_byte(pix_byte[p]),
            .ctrl_reset(ctrl_reset[p]), .status_byte(STAT), .read_byte(RDAT), .read_taken(read_taken[p]));
    end
    dhb_props dhb_props_i (.sys_clk(sys_clk), .nrst(nrst), .hd_oe(dhb_if_i[0].hd_oe), .dd_oe(dhb_if_i[0].dd_oe),
        .host_data_bus(dhb_if_i[0].host_data_bus), .rd_strobe(dhb_if_i[0].rd_strobe),
        .wr_strobe(dhb_if_i[0].wr_strobe), .cs_n(dhb_if_i[0].cs_n), .init_n(dhb_if_i[0].init_n));

    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;

    // pulses last one cycle, so one falling edge always sees them
    // only one pair is busy at a time, so the counts are shared
    always @(negedge sys_clk) begin
        for (int p = 0; p < 3; p++) begin
            if (cmd_valid[p] === 1'b1) begin
                n_cmd++;
                last_cmd = cmd_byte[p];
            end
            if (pix_valid[p] === 1'b1) begin
                n_pix++;
                last_pix = pix_byte[p];
            end
            if (rsp_valid[p] === 1'b1) begin
                n_rsp++;
                last_rsp = rsp_data[p];
            end
            if (read_taken[p] === 1'b1) n_tk++;
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test;
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wait_cnt(ref int cnt, input int base);
        int n;
        n = 0;
        while (cnt == base && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic wait_rst(input int p, input logic v);
        int n;
        n = 0;
        while (ctrl_reset[p] !== v && n < 600) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic send(input int p, input logic rd, input logic dc, input logic ini, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready[p] !== 1'b1 && n < 600) begin
            @(negedge sys_clk);
            n++;
        end
        req_valid[p] = 1'b1;
        req_read = rd;
        req_dc = dc;
        req_init = ini;
        req_data = d;
        @(negedge sys_clk);
        req_valid[p] = 1'b0;
        req_init = 1'b0;
    endtask

    task automatic t_write(input int p, input logic dc, input logic [7:0] d);
        int c0;
        int p0;
        c0 = n_cmd;
        p0 = n_pix;
        send(p, 1'b0, dc, 1'b0, d);
        if (dc)
            wait_cnt(n_pix, p0);
        else
            wait_cnt(n_cmd, c0);
        chk("cmd_count", 8'(!dc), 8'(n_cmd - c0));
        chk("pix_count", 8'(dc), 8'(n_pix - p0));
        chk("write_byte", d, dc ? last_pix : last_cmd);
    endtask

    task automatic t_read(input int p, input logic dc);
        int r0;
        int t0;
        r0 = n_rsp;
        t0 = n_tk;
        send(p, 1'b1, dc, 1'b0, 8'h00);
        wait_cnt(n_rsp, r0);
        chk("rsp_count", 8'h01, 8'(n_rsp - r0));
        chk("read_byte", dc ? RDAT : STAT, last_rsp);
        chk("taken_count", 8'(dc), 8'(n_tk - t0));
    endtask

    task automatic t_init(input int p);
        send(p, 1'b0, 1'b0, 1'b1, 8'h00);
        wait_rst(p, 1'b1);
        chk("ctrl_reset_on", 8'h01, {7'h00, ctrl_reset[p]});
        wait_rst(p, 1'b0);
        chk("ctrl_reset_off", 8'h00, {7'h00, ctrl_reset[p]});
    endtask

    initial begin
        nrst = 1'b0;
        req_valid = '0;
        req_read = 1'b0;
        req_dc = 1'b0;
        req_init = 1'b0;
        req_data = 8'h00;
        repeat (16) @(negedge sys_clk);
        chk("ctrl_reset_in_reset", 8'h01, {7'h00, ctrl_reset[0]});
        nrst = 1'b1;
        @(negedge sys_clk);
        t_write(0, 1'b0, 8'h00);
        t_write(0, 1'b0, 8'hFF);
        t_write(0, 1'b1, 8'hA5);
        t_read(0, 1'b0);
        t_read(0, 1'b1);
        t_init(0);
        t_write(0, 1'b1, 8'h3C);
        t_write(1, 1'b0, 8'h81);
        t_write(1, 1'b1, 8'h7E);
        t_read(1, 1'b0);
        t_read(1, 1'b1);
        t_write(2, 1'b0, 8'hC3);
        t_write(2, 1'b1, 8'h96);
        finish_test;
    end

    // thirteen requests, some 115 cycles each on the parallel pairs and some 1250 on the serial pair, with ample margin
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
